// ===== logic/updown_threshold_pkg.sv
// constants and types shared by the up/down threshold counter
package updown_threshold_pkg;
  localparam int COUNT_W = 32;
  localparam logic [31:0] COUNT_MAX = 32'h05F5_E0FF; // largest value a limit may take
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] SCAN_DIV_DEFAULT = 32'h0000_C350; // 1 ms scan at 50 MHz
  localparam logic [31:0] SCAN_DIV_ONE = 32'h0000_0001;
  localparam int SCAN_W = 32;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_CLEAR = 2'b01,
    ST_EDIT = 2'b10
  } run_state_t;
endpackage

// ===== logic/retain_store.sv
// retained copy of the count, loaded back after power-up
`timescale 1ns/10ps
module retain_store #(
  parameter int WIDTH = 32
) (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic valid_o
);
  logic [WIDTH-1:0] mem_ff;
  logic valid_ff;
  // no reset here on purpose: the content must survive a logic reset
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_ff <= wr_data_i;
      valid_ff <= 1'b1;
    end
  end
  // read data from a register
  always_ff @(posedge core_clk_i) begin
    rd_data_o <= mem_ff;
    valid_o <= valid_ff;
  end
endmodule

// ===== logic/updown_threshold_counter.sv
// up/down pulse counter with threshold switching output
`timescale 1ns/10ps
// What this block does
// R1 - pulse rising edge counts, direction picks sign
// R2 - clear input sets count to zero
// R3 - while clear held, output low, no counting
// R4 - on>=off: set at on, clear below off
// R5 - on<off: output high inside window only
// R6 - compare once per scan cycle
// R7 - limits from constants or other blocks
// R8 - operator edits limits and count when editing
// R9 - counting starts from preload value
// R10 - retention keeps count across power loss
// R11 - hysteresis band keeps previous output
module updown_threshold_counter
  import updown_threshold_pkg::*;
#(
  parameter int WIDTH = COUNT_W,
  parameter logic [31:0] SCAN_DIV = SCAN_DIV_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic pulse_i,
  input wire logic dir_down_i,
  input wire logic clear_i,
  input wire logic on_sel_ext_i,
  input wire logic [WIDTH-1:0] on_const_i,
  input wire logic [WIDTH-1:0] on_ext_i,
  input wire logic off_sel_ext_i,
  input wire logic [WIDTH-1:0] off_const_i,
  input wire logic [WIDTH-1:0] off_ext_i,
  input wire logic [WIDTH-1:0] preload_i,
  input wire logic retain_en_i,
  input wire logic edit_mode_i,
  input wire logic edit_count_we_i,
  input wire logic [WIDTH-1:0] edit_count_i,
  output logic switch_o,
  output logic [WIDTH-1:0] count_o,
  output logic scan_tick_o
);
  // synchroniser stages, edge memory and the registered state
  logic [1:0] pulse_sync_ff;
  logic pulse_prev_ff;
  logic [1:0] dir_sync_ff;
  logic [1:0] clr_sync_ff;
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic switch_ff;
  logic nxt_switch;
  logic [SCAN_W-1:0] scan_cnt_ff;
  logic scan_tick_ff;
  logic started_ff;
  logic [WIDTH-1:0] on_lim;
  logic [WIDTH-1:0] off_lim;
  logic pulse_rise;
  logic [WIDTH-1:0] ret_data;
  logic ret_valid;
  run_state_t state_ff;
  run_state_t nxt_state;

  // field inputs pass two flops; first stage read only by the second
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pulse_sync_ff <= 2'b00;
      dir_sync_ff <= 2'b00;
      clr_sync_ff <= 2'b00;
      pulse_prev_ff <= 1'b0;
    end else begin
      pulse_sync_ff <= {pulse_sync_ff[0], pulse_i};
      dir_sync_ff <= {dir_sync_ff[0], dir_down_i};
      clr_sync_ff <= {clr_sync_ff[0], clear_i};
      pulse_prev_ff <= pulse_sync_ff[1];
    end
  end

  // only 0 to 1 transitions count
  // edge memory idles low like the pin, so reset brings no false count
  assign pulse_rise = pulse_sync_ff[1] & ~pulse_prev_ff; // R1

  // one helper for both limits keeps their selection alike
  function automatic logic [WIDTH-1:0] pick_limit(
    input logic sel_ext,
    input logic [WIDTH-1:0] ext_val,
    input logic [WIDTH-1:0] const_val
  );
    pick_limit = sel_ext ? ext_val : const_val;
  endfunction

  // limit source select, live value taken each cycle
  assign on_lim = pick_limit(on_sel_ext_i, on_ext_i, on_const_i); // R7
  assign off_lim = pick_limit(off_sel_ext_i, off_ext_i, off_const_i); // R7

  // clear outranks editing, editing outranks counting
  always_comb begin
    if (clr_sync_ff[1]) begin
      nxt_state = ST_CLEAR; // R3
    end else if (edit_mode_i) begin
      nxt_state = ST_EDIT; // R8
    end else begin
      nxt_state = ST_RUN;
    end
  end

  // state kept registered, so the switch drops one cycle after the count
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // count update; pulses during clear are dropped
  // the count is unsigned: counting down past zero wraps to all ones
  always_comb begin
    nxt_count = count_ff;
    case (nxt_state)
      ST_CLEAR: begin
        nxt_count = '0; // R2
      end
      ST_EDIT: begin
        if (edit_count_we_i) begin
          nxt_count = edit_count_i; // R8
        end
      end
      ST_RUN: begin
        if (pulse_rise) begin
          if (dir_sync_ff[1]) begin
            nxt_count = count_ff - 1'b1; // R1
          end else begin
            nxt_count = count_ff + 1'b1; // R1
          end
        end
      end
      default: begin
        nxt_count = count_ff;
      end
    endcase
  end

  // first cycle after reset: retained value if enabled and valid, else preload
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      count_ff <= '0;
    end else if (!started_ff) begin
      if (retain_en_i && ret_valid) begin
        count_ff <= ret_data; // R10
      end else begin
        count_ff <= preload_i; // R9
      end
    end else begin
      count_ff <= nxt_count;
    end
  end

  // start value loaded; gates the compare and the retention writes
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      started_ff <= 1'b0;
    end else begin
      started_ff <= 1'b1;
    end
  end

  // scan cycle divider; comparison waits for the tick
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      scan_cnt_ff <= '0;
      scan_tick_ff <= 1'b0;
    end else if (scan_cnt_ff >= SCAN_DIV - SCAN_DIV_ONE) begin
      scan_cnt_ff <= '0;
      scan_tick_ff <= 1'b1; // R6
    end else begin
      scan_cnt_ff <= scan_cnt_ff + 1'b1;
      scan_tick_ff <= 1'b0;
    end
  end

  // threshold rule; narrow windows between scans can be missed
  always_comb begin
    nxt_switch = switch_ff;
    if (on_lim >= off_lim) begin
      if (count_ff >= on_lim) begin
        nxt_switch = 1'b1; // R4
      end else if (count_ff < off_lim) begin
        nxt_switch = 1'b0; // R4
      end else begin
        nxt_switch = switch_ff; // R11
      end
    end else begin
      nxt_switch = (count_ff >= on_lim) && (count_ff < off_lim); // R5
    end
  end

  // switch moves only on a scan tick, except that clear forces it low
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      switch_ff <= 1'b0;
    end else if (state_ff == ST_CLEAR) begin
      switch_ff <= 1'b0; // R3
    end else if (scan_tick_ff && started_ff) begin
      switch_ff <= nxt_switch; // R6
    end
  end

  // retention copy written each scan while enabled
  // changes after the last tick before power loss are not kept
  retain_store #(
    .WIDTH(WIDTH)
  ) u_retain (
    .core_clk_i(core_clk_i),
    .wr_en_i(retain_en_i && started_ff && scan_tick_ff), // R10
    .wr_data_i(count_ff),
    .rd_data_o(ret_data),
    .valid_o(ret_valid)
  );

  // outputs come straight from their flops
  assign switch_o = switch_ff;
  assign count_o = count_ff;
  assign scan_tick_o = scan_tick_ff;
endmodule

// ===== tb/utc_chk.sv
// assertions watching the up/down threshold counter ports
`timescale 1ns/10ps
module utc_chk #(
  parameter int WIDTH = 32,
  parameter logic [31:0] SCAN_DIV = 32'h0000_0004
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic pulse_i,
  input wire logic dir_down_i,
  input wire logic clear_i,
  input wire logic on_sel_ext_i,
  input wire logic [WIDTH-1:0] on_const_i,
  input wire logic [WIDTH-1:0] on_ext_i,
  input wire logic off_sel_ext_i,
  input wire logic [WIDTH-1:0] off_const_i,
  input wire logic [WIDTH-1:0] off_ext_i,
  input wire logic edit_mode_i,
  input wire logic edit_count_we_i,
  input wire logic [WIDTH-1:0] edit_count_i,
  input wire logic switch_o,
  input wire logic [WIDTH-1:0] count_o,
  input wire logic scan_tick_o
);
  localparam int SD2 = SCAN_DIV - 1;
  logic [3:0] clr_sh_ff;
  logic [WIDTH-1:0] on_l, off_l;
  logic quiet, win, calm;
  // clear history: the core sees clear late, through its synchroniser
  always_ff @(posedge core_clk_i) begin
    clr_sh_ff <= reset_i ? 4'h0 : {clr_sh_ff[2:0], clear_i};
  end
  // effective limits and window test
  assign on_l = on_sel_ext_i ? on_ext_i : on_const_i;
  assign off_l = off_sel_ext_i ? off_ext_i : off_const_i;
  assign quiet = !clear_i && clr_sh_ff == 4'h0;
  // editing pauses counting, so steps are only checked outside it
  assign calm = quiet && !edit_mode_i;
  assign win = count_o >= on_l && count_o < off_l;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  count_step_a: assert property ($rose(pulse_i) ##0 (calm && $stable(dir_down_i))[*4] |=>
    count_o == $past(count_o, 3) + (dir_down_i ? -1 : 1)) else $error("bad count step");
  clear_hold_a: assert property (clear_i && clr_sh_ff == 4'hF |=>
    !switch_o && count_o == 0) else $error("clear not held");
  scan_period_a: assert property (scan_tick_o |=> !scan_tick_o ##SD2 scan_tick_o)
    else $error("bad scan period");
  switch_rise_a: assert property ($rose(switch_o) |-> $past(scan_tick_o))
    else $error("switch rose off scan");
  hyst_set_a: assert property (quiet && scan_tick_o && on_l >= off_l && count_o >= on_l
    |=> switch_o) else $error("switch not set");
  hyst_clr_a: assert property (quiet && scan_tick_o && on_l >= off_l && count_o < off_l
    |=> !switch_o) else $error("switch not cleared");
  hyst_hold_a: assert property (quiet && scan_tick_o && on_l >= off_l && count_o >= off_l
    && count_o < on_l |=> $stable(switch_o)) else $error("band did not hold");
  window_a: assert property (quiet && scan_tick_o && on_l < off_l |=>
    switch_o == $past(win)) else $error("window wrong");
  edit_load_a: assert property (quiet && edit_mode_i && edit_count_we_i && !$past(reset_i)
    |=> count_o == $past(edit_count_i)) else $error("edit load missed");
  edit_hold_a: assert property (quiet && edit_mode_i && !edit_count_we_i
    && !$past(reset_i) |=> $stable(count_o)) else $error("count moved while editing");
endmodule
bind updown_threshold_counter utc_chk #(.WIDTH(WIDTH), .SCAN_DIV(SCAN_DIV)) watch (.core_clk_i,
  .reset_i, .pulse_i, .dir_down_i, .clear_i, .on_sel_ext_i, .on_const_i, .on_ext_i,
  .off_sel_ext_i, .off_const_i, .off_ext_i, .edit_mode_i, .edit_count_we_i, .edit_count_i,
  .switch_o, .count_o, .scan_tick_o);

// ===== tb/pulse_src.sv
// field pulse source driving the count input
`timescale 1ns/10ps
module pulse_src (
  input wire logic clk_i,
  output logic pulse_o
);
  initial pulse_o = 1'b0;
  // each level lasts hi clocks or more, so a slow source is just a larger hi
  task automatic pulse_once(int hi);
    @(posedge clk_i);
    #1 pulse_o = 1'b1;
    repeat (hi) @(posedge clk_i);
    #1 pulse_o = 1'b0;
    repeat (hi) @(posedge clk_i);
    #1;
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the up/down threshold counter
`timescale 1ns/10ps
module tb_top;
  logic core_clk_i = 0, reset_i = 1, dir_down_i = 0, clear_i = 0, pulse_i;
  logic on_sel_ext_i = 0, off_sel_ext_i = 0, switch_o, scan_tick_o;
  logic retain_en_i = 0, edit_mode_i = 0, edit_count_we_i = 0;
  logic [31:0] on_const_i = 0, on_ext_i = 0, off_const_i = 0, off_ext_i = 0;
  logic [31:0] preload_i = 0, edit_count_i = 0, count_o, c;
  logic [31:0] q[$];
  int mismatches = 0, comparisons = 0, cyc = 0;
  always #10 core_clk_i = ~core_clk_i;
  pulse_src src (.clk_i(core_clk_i), .pulse_o(pulse_i));
  updown_threshold_counter #(.SCAN_DIV(32'h0000_0004)) dut (.core_clk_i, .reset_i, .pulse_i,
    .dir_down_i, .clear_i, .on_sel_ext_i, .on_const_i, .on_ext_i, .off_sel_ext_i,
    .off_const_i, .off_ext_i, .preload_i, .retain_en_i, .edit_mode_i,
    .edit_count_we_i, .edit_count_i, .switch_o, .count_o, .scan_tick_o);
  task automatic chk(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // an unnoted count change meets x and fails
  always @(count_o) chk(count_o, q.size() ? q.pop_front() : 'x);
  // pulses one way, then the switch after the next scan
  task automatic step(int n, logic d, logic e);
    dir_down_i = d;
    repeat (3) @(posedge core_clk_i);
    #1;
    repeat (n) begin
      c = d ? c - 1 : c + 1;
      q.push_back(c);
      src.pulse_once(2 + n % 3);
    end
    @(posedge core_clk_i iff scan_tick_o);
    @(posedge core_clk_i);
    #1 chk(switch_o, e);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles needed
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h1a46_f6f8));
    preload_i = 32'h0000_0100 + $urandom % 256;
    c = preload_i;
    q = '{32'h0000_0000, c};
    repeat (10) @(posedge core_clk_i);
    #1 reset_i = 0;
    step(5 + $urandom % 4, 0, 1);
    step(3, 1, 1);
    $display("count test done");
    on_const_i = c + 4;
    off_const_i = c + 2;
    step(0, 0, 0);
    step(4, 0, 1);
    step(1, 1, 1);
    step(2, 1, 0);
    $display("hysteresis test done");
    on_sel_ext_i = 1;
    off_sel_ext_i = 1;
    on_ext_i = c + 1;
    off_ext_i = c + 3;
    step(1, 0, 1);
    step(2, 0, 0);
    step(1, 1, 1);
    $display("window test done");
    // edit mode: pulse dropped, count and limits rewritten by the operator
    edit_mode_i = 1;
    src.pulse_once(2);
    c = 32'h0000_0400 + $urandom % 256;
    q.push_back(c);
    edit_count_i = c;
    on_ext_i = c;
    off_ext_i = c + 1;
    edit_count_we_i = 1;
    @(posedge core_clk_i);
    #1 edit_count_we_i = 0;
    edit_mode_i = 0;
    step(0, 0, 1);
    $display("edit test done");
    // retention across a reset in mid-run; preload lies far below c
    retain_en_i = 1;
    repeat (8) @(posedge core_clk_i);
    #1 reset_i = 1;
    q.push_back(32'h0000_0000);
    q.push_back(c);
    repeat (2) @(posedge core_clk_i);
    #1 reset_i = 0;
    step(0, 0, 1);
    $display("retention test done");
    clear_i = 1;
    c = 0;
    q.push_back(c);
    src.pulse_once(2);
    repeat (4) @(posedge core_clk_i);
    #1 chk(switch_o, 0);
    chk(q.size(), 0);
    $display("clear test done");
    finish_test();
  end
endmodule
